/* frequency_setpoint_selector_test.sv */
// Bench: APB accesses, panel model, expected setpoints.
// Assumes fss_top, fss_panel and fss_pkg are compiled first.
`timescale 1ns/1ps
`include "fss_cfg.svh"
module frequency_setpoint_selector_test;
  logic               pclk, presetn, psel, penable, pwrite, pready, er;
  logic               pslverr_w, en;
  logic [9:0]         pot_pos;
  fss_pkg::fss_freq_t fq;
  // Source codes of the remaining same-clock inputs, ai2 up to pot2
  logic [3:0]  sc [6] = '{4'h4, 4'h6, 4'h7, 4'h8, 4'hA, 4'hB};
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd, t;
  fss_pkg::fss_pins_s pins;
  fss_pkg::fss_srcs_s srcs;
  int                 err_total, checks_done, n;
  // Mode, serial setpoint and expected final per table row
  logic [3:0]  md [10] = '{4'h0,4'h1,4'h2,4'h3,4'h4,4'h5,4'h2,4'h3,4'h4,4'h5};
  logic [31:0] cm [10] = '{32'h0BB8,32'h0BB8,32'h0BB8,32'h0BB8,32'h0BB8,
    32'h0BB8,32'h03E8,32'h03E8,32'h03E8,32'h03E8};
  logic [31:0] ex [10] = '{32'h0BB8,32'h1388,32'h03E8,32'h03E8,32'h0BB8,
    32'h07D0,32'hFFFFFC18,32'h03E8,32'h07D0,32'h03E8};
  fss_top #(.GATE_CYC(8000)) dut_u (.pclk(pclk), .presetn(presetn),
    .en(en), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr_w), .pins(pins), .srcs(srcs), .pot_pos(pot_pos),
    .freq_final(fq));
  fss_panel panel_u (.pclk(pclk), .pins(pins));
  // 40 MHz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic give_verdict();
    if (err_total == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  // One APB transfer; read data and error taken at the pready edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d = 32'h0);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr_w;
    {psel, penable} <= 2'b00;
    if (n >= 20) begin
      err_total++;
      give_verdict();
    end
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    srcs = '0;
    en = 1'b1;
    pot_pos = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `FSS_OFF_CTRL); chk("ctrl", 32'h0039, rd);
    apb(0, `FSS_OFF_WGT); chk("k", 32'h0064, rd);
    apb(1, `FSS_OFF_WGT, 32'h0); chk("k low", 32'h1, {31'h0, er});
    apb(1, `FSS_OFF_WGT, 32'h03E9); chk("k hi", 32'h1, {31'h0, er});
    apb(0, 8'h28); chk("unmapped", 32'h1, {31'h0, er});
    apb(1, `FSS_OFF_WGT, 32'h00C8);
    srcs.ai1 <= 16'h03E8;
    // A from serial setpoint, B from first analog input, K = 2.00
    for (int i = 0; i < 10; i++) begin
      apb(1, `FSS_OFF_COMM, cm[i]);
      apb(1, `FSS_OFF_CTRL, {20'h0, md[i], 8'h32});
      repeat (3) @(posedge pclk);
      apb(0, `FSS_OFF_STAT); chk("mix", ex[i], rd);
      chk("final", ex[i], 32'(fq));
    end
    // Remaining same-clock sources as A, each code in turn
    for (int j = 1; j < 7; j++) begin
      srcs[111 - 16 * j -: 16] <= 16'(j * 16'h0111);
      apb(1, `FSS_OFF_CTRL, {24'h0, 4'h3, sc[j - 1]});
      repeat (3) @(posedge pclk);
      apb(0, `FSS_OFF_STAT); chk("src", j * 32'h0111, rd);
    end
    apb(1, `FSS_OFF_CTRL, 32'h0632);
    panel_u.lvl(4, 1'b1);
    repeat (6) @(posedge pclk);
    apb(0, `FSS_OFF_STAT); chk("sw kb", 32'h07D0, rd);
    panel_u.lvl(4, 1'b0);
    repeat (6) @(posedge pclk);
    apb(0, `FSS_OFF_STAT); chk("sw a", 32'h03E8, rd);
    // Terminal mode, one step every 2 cycles
    apb(1, `FSS_OFF_TINIT, 32'h03E8);
    apb(1, `FSS_OFF_RATE, 32'h2);
    apb(1, `FSS_OFF_CTRL, 32'h0031);
    panel_u.lvl(7, 1'b1);
    repeat (40) @(posedge pclk);
    panel_u.lvl(6, 1'b1);
    repeat (6) @(posedge pclk);
    apb(0, `FSS_OFF_TADJ); t = rd;
    chk("rise", 32'h1, {31'h0, t > 32'hA && t < 32'h8000});
    repeat (20) @(posedge pclk);
    apb(0, `FSS_OFF_TADJ); chk("hold", t, rd);
    apb(0, `FSS_OFF_STAT); chk("sum", t + 32'h03E8, rd);
    panel_u.lvl(7, 1'b0);
    repeat (12) @(posedge pclk);
    apb(0, `FSS_OFF_TADJ);
    chk("fall", 32'h1, {31'h0, rd < t});
    panel_u.lvl(6, 1'b0);
    panel_u.tap(5);
    repeat (4) @(posedge pclk);
    apb(0, `FSS_OFF_TADJ); chk("clr", 32'h0, rd);
    // Key mode from 10.00 Hz
    apb(1, `FSS_OFF_KINIT, 32'h03E8);
    apb(1, `FSS_OFF_CTRL, 32'h4030);
    panel_u.tap(10);
    repeat (4) @(posedge pclk);
    apb(0, `FSS_OFF_STAT); chk("key", 32'h03E9, rd);
    panel_u.tap(8);
    repeat (4) @(posedge pclk);
    apb(0, `FSS_OFF_KADJ); chk("mfk", 32'h0, rd);
    panel_u.tap(10);
    panel_u.tap(0);
    repeat (4) @(posedge pclk);
    apb(0, `FSS_OFF_KINIT); chk("save", 32'h03E9, rd);
    // A key press while the enable is low is never seen
    en <= 1'b0;
    panel_u.tap(10);
    repeat (2) @(posedge pclk);
    en <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(0, `FSS_OFF_KADJ); chk("freeze", 32'h0, rd);
    // Potentiometer source: full travel gives maximum frequency
    apb(1, `FSS_OFF_CTRL, 32'h0039);
    pot_pos <= 10'h3FF;
    repeat (4) @(posedge pclk);
    apb(0, `FSS_OFF_STAT); chk("pot full", 32'h1388, rd);
    pot_pos <= 10'h200;
    repeat (4) @(posedge pclk);
    apb(0, `FSS_OFF_STAT); chk("pot mid", 32'h09C6, rd);
    // Pulse source: one pulse per 1600 cycles is half of full scale
    apb(1, `FSS_OFF_CTRL, 32'h0035);
    for (int j = 0; j < 16; j++) begin
      panel_u.tap(1);
      repeat (1595) @(posedge pclk);
    end
    apb(0, `FSS_OFF_STAT); chk("pulse", 32'h09C4, rd);
    give_verdict();
  end
endmodule // frequency_setpoint_selector_test

/* fss_cfg.svh */
// Constants of the frequency setpoint selector: offsets, fields, resets.
// Included by the top module; holds definitions only.
`ifndef FSS_CFG_SVH
`define FSS_CFG_SVH

// Register byte offsets on the APB bus
`define FSS_OFF_CTRL  8'h00
`define FSS_OFF_KINIT 8'h04
`define FSS_OFF_TINIT 8'h08
`define FSS_OFF_WGT   8'h0C
`define FSS_OFF_LIM   8'h10
`define FSS_OFF_RATE  8'h14
`define FSS_OFF_COMM  8'h18
`define FSS_OFF_STAT  8'h1C
`define FSS_OFF_KADJ  8'h20
`define FSS_OFF_TADJ  8'h24

// Control register field positions
`define FSS_SRCA_LSB 0
`define FSS_SRCB_LSB 4
`define FSS_MODE_LSB 8
`define FSS_KSTO_BIT 12
`define FSS_TSTO_BIT 13
`define FSS_MFK_BIT  14

// Reset values, frequencies in 0.01 Hz, weight in 0.01
`define FSS_SRCA_RST  4'h9
`define FSS_SRCB_RST  4'h3
`define FSS_MODE_RST  4'h0
`define FSS_SRC_LAST  4'hB
`define FSS_MODE_LAST 4'h9
`define FSS_INIT_RST  16'h1388
`define FSS_MAXF_RST  16'h1388
`define FSS_LOWF_RST  16'h0000
`define FSS_K_RST     16'h0064
`define FSS_K_MIN     16'h0001
`define FSS_K_MAX     16'h03E8
`define FSS_K_SCALE   32'h0000_0064
`define FSS_RATE_RST  16'h0FA0
`define FSS_POT_FULL  32'h0000_03FF

// Timing: clock rate, pulse gate window, top pulse rate
`define FSS_CLK_HZ       40000000
`define FSS_GATE_MS      10
`define FSS_PULSE_MAX_HZ 50000

`endif

/* fss_panel.sv */
// Far-side model: operator panel keys and control terminals.
// Assumes pclk from the bench; every change follows a rising edge.
`timescale 1ns/1ps
module fss_panel (
  input  wire logic          pclk,
  output fss_pkg::fss_pins_s pins
);
  // All keys released and terminals open at start
  initial pins = '0;
  // Sets one pin level just after an edge
  task automatic lvl(input int i, input logic v);
    @(posedge pclk);
    pins[i] <= v;
  endtask
  // Short press, long enough for the two-stage sync
  task automatic tap(input int i);
    lvl(i, 1'b1);
    repeat (4) @(posedge pclk);
    pins[i] <= 1'b0;
  endtask
endmodule // fss_panel

/* fss_pkg.sv */
// Types of the frequency setpoint selector.
// Used by the top module and by whoever drives its struct ports.
package fss_pkg;

  // Frequency source codes, shared by sources A and B
  typedef enum logic [3:0] {
    FSS_SRC_KEY   = 4'h0, FSS_SRC_TERM  = 4'h1, FSS_SRC_COMM = 4'h2,
    FSS_SRC_AN1   = 4'h3, FSS_SRC_AN2   = 4'h4, FSS_SRC_PULSE = 4'h5,
    FSS_SRC_SEQ   = 4'h6, FSS_SRC_MSPD  = 4'h7, FSS_SRC_LOOP = 4'h8,
    FSS_SRC_POT   = 4'h9, FSS_SRC_SOLAR = 4'hA, FSS_SRC_POT2 = 4'hB
  } fss_src_e;

  // Combination modes of A and K*B
  typedef enum logic [3:0] {
    FSS_MODE_A     = 4'h0, FSS_MODE_ADD   = 4'h1, FSS_MODE_SUB  = 4'h2,
    FSS_MODE_ABS   = 4'h3, FSS_MODE_MAX   = 4'h4, FSS_MODE_MIN  = 4'h5,
    FSS_MODE_SWKB  = 4'h6, FSS_MODE_SWADD = 4'h7, FSS_MODE_SWSUB = 4'h8,
    FSS_MODE_RSV9  = 4'h9
  } fss_mode_e;

  // Asynchronous panel keys and control terminals
  typedef struct packed {
    logic key_up;     // Panel increase key or encoder step up
    logic key_down;   // Panel decrease key or encoder step down
    logic mfk;        // multi_function_key
    logic term_up;    // Increase terminal, high when closed
    logic term_down;  // Decrease terminal, high when closed
    logic term_clear; // Increase/decrease clear terminal
    logic sw_kb;      // Switch A to K*B terminal
    logic sw_add;     // Switch A to A+K*B terminal
    logic sw_sub;     // Switch A to A-K*B terminal
    logic pulse;      // sixth_digital_input pulse train
    logic pwr_loss;   // Power loss warning
  } fss_pins_s;

  // Same-clock source values, 0.01 Hz units
  typedef struct packed {
    logic [15:0] ai1;   // first_analog_input after scaling
    logic [15:0] ai2;   // second_analog_input after scaling
    logic [15:0] seq;   // Sequence program stage frequency
    logic [15:0] mspd;  // Multi-speed frequency
    logic [15:0] loop;  // Process loop output
    logic [15:0] solar; // solar_tracking_source
    logic [15:0] pot2;  // Second panel potentiometer
  } fss_srcs_s;

  typedef logic signed [17:0] fss_freq_t;

endpackage

/* fss_top.sv */
// Frequency setpoint selector: picks sources A and B and combines them.
// Assumes an APB master on pclk; pins in fss_pins_s are asynchronous,
// source values and pot_pos come from logic on pclk.
`timescale 1ns/1ps
`include "fss_cfg.svh"

// How it works
// - Key mode starts at panel init, keys adjust
// - Power loss saves key frequency unless disabled
// - Terminal mode starts at terminal init value
// - Increase input alone raises the setpoint
// - Decrease input alone lowers the setpoint
// - Both or neither input holds setpoint
// - Power loss saves terminal frequency if enabled
// - Terminal ramp uses a programmable rate
// - Setpoint is init plus adjust, clamped
// - Clear input zeroes terminal adjust amount
// - Clear-set multi-function key zeroes key adjust
// - Code 2 uses host-sent serial setpoint
// - Pulse source measures sixth input rate
// - Potentiometer maps zero to maximum frequency
// - Source B codes 0 to 11, default 3
// - Combination 0 to 9, zero gives A
// - Mode 1 gives A plus K times B
// - A mode gives A minus K times B
// - Mode 3 gives absolute A minus KB
// - A mode gives larger of A, KB
// - Mode 5 gives smaller of A, KB
// - Mode 6 switch input selects KB or A
// - Weight K spans 0.01 to 10.00, default 1.00
module fss_top #(
  parameter int unsigned GATE_CYC = `FSS_CLK_HZ / 1000 * `FSS_GATE_MS
) (
  input  logic                pclk,
  input  logic                presetn,
  input  logic                en,
  input  logic [7:0]          paddr,
  input  logic                psel,
  input  logic                penable,
  input  logic                pwrite,
  input  logic [31:0]         pwdata,
  output logic [31:0]         prdata,
  output logic                pready,
  output logic                pslverr,
  input  fss_pkg::fss_pins_s  pins,
  input  fss_pkg::fss_srcs_s  srcs,
  input  logic [9:0]          pot_pos,
  output fss_pkg::fss_freq_t  freq_final
);

  // Cycles per period of the top pulse rate, and full-scale count
  localparam int unsigned PDIV  = `FSS_CLK_HZ / `FSS_PULSE_MAX_HZ;
  localparam int unsigned PFULL = (GATE_CYC < PDIV) ? 1 : GATE_CYC / PDIV;

  // Clamp a signed value into lo..hi
  function automatic logic [15:0] fss_clamp(input logic signed [19:0] v,
                                            input logic [15:0] lo,
                                            input logic [15:0] hi);
    if (v < $signed({4'h0, lo}))
      fss_clamp = lo;
    else if (v > $signed({4'h0, hi}))
      fss_clamp = hi;
    else
      fss_clamp = v[15:0];
  endfunction

  // Adjust amount after one step, kept so the sum stays in range
  function automatic logic signed [17:0] fss_step(
      input logic signed [17:0] adj, input logic [15:0] init,
      input logic signed [1:0] dir, input logic [15:0] lo,
      input logic [15:0] hi);
    logic signed [19:0] sum;
    logic [19:0]        dif;
    sum = $signed({4'h0, init}) + 20'(adj) + 20'(dir);
    dif = {4'h0, fss_clamp(sum, lo, hi)} - {4'h0, init};
    fss_step = $signed(dif[17:0]);
  endfunction

  // Pin synchronisers and edge history
  fss_pkg::fss_pins_s sync1_q;  // First stage, read by sync2_q only
  fss_pkg::fss_pins_s sync2_q;  // Synchronised pins
  fss_pkg::fss_pins_s prev_q;   // Last synchronised value

  // Registers
  fss_pkg::fss_src_e  src_a_q;   // Main source A
  fss_pkg::fss_src_e  src_b_q;   // Auxiliary source B
  fss_pkg::fss_mode_e mode_q;    // Combination mode
  logic               ksto_dis_q; // Key save disable
  logic               tsto_dis_q; // Terminal save disable
  logic               mfk_clr_q;  // Key acts as key-frequency clear
  logic [15:0]        kinit_q;   // Panel initial frequency
  logic [15:0]        tinit_q;   // Terminal initial frequency
  logic [15:0]        k_q;       // Weight K in 0.01
  logic [15:0]        lowf_q;    // Lower limit frequency
  logic [15:0]        maxf_q;    // Maximum output frequency
  logic [15:0]        rate_q;    // Cycles per terminal step
  logic [15:0]        comm_q;    // Serial frequency command

  // Adjustment and measurement state
  logic signed [17:0] kadj_q;    // Key adjust amount
  logic signed [17:0] tadj_q;    // Terminal adjust amount
  logic [15:0]        rcnt_q;    // Terminal rate counter
  logic [19:0]        gate_q;    // Pulse gate timer
  logic [15:0]        pcnt_q;    // Pulses in current gate
  logic [15:0]        phz_q;     // Pulses in last full gate

  // Bus answer and final output
  logic [31:0]        prdata_q;
  logic               pready_q;
  logic               pslverr_q;
  fss_pkg::fss_freq_t fin_q;

  // Combinational terms
  logic               key_up_e, key_dn_e, mfk_e, tclr_e, pwr_e, pulse_e;
  logic signed [1:0]  kdir, tdir;
  logic               key_use, rtick, gate_end;
  logic [15:0]        kset, tset, pulse_sp, pot_sp, a_v, b_v;
  logic [15:0]        sv [12];
  logic [31:0]        pprod, oprod, kprod;
  logic signed [21:0] as_c, kb_c, f_c;
  logic               setup, wr, miss, ro, bad;
  logic [31:0]        rd_c;

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign freq_final = fin_q;

  // Two-stage synchroniser for all pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (en) begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  // Previous value for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prev_q <= '0;
    else if (en)
      prev_q <= sync2_q;
  end

  // Rising edges of event pins
  assign key_up_e = sync2_q.key_up & ~prev_q.key_up;
  assign key_dn_e = sync2_q.key_down & ~prev_q.key_down;
  assign mfk_e    = sync2_q.mfk & ~prev_q.mfk;
  assign tclr_e   = sync2_q.term_clear & ~prev_q.term_clear;
  assign pwr_e    = sync2_q.pwr_loss & ~prev_q.pwr_loss;
  assign pulse_e  = sync2_q.pulse & ~prev_q.pulse;

  // Step directions; opposite or idle inputs give zero
  always_comb begin
    kdir = 2'sd0;
    if (key_up_e & ~key_dn_e)
      kdir = 2'sd1;
    else if (key_dn_e & ~key_up_e)
      kdir = -2'sd1;
    tdir = 2'sd0;
    if (sync2_q.term_up & ~sync2_q.term_down)
      tdir = 2'sd1;
    else if (sync2_q.term_down & ~sync2_q.term_up)
      tdir = -2'sd1;
  end

  // Setpoints are init plus adjust, held within limits
  assign kset = fss_clamp($signed({4'h0, kinit_q}) + 20'(kadj_q),
                          lowf_q, maxf_q);
  assign tset = fss_clamp($signed({4'h0, tinit_q}) + 20'(tadj_q),
                          lowf_q, maxf_q);
  assign key_use = (src_a_q == fss_pkg::FSS_SRC_KEY) |
                   (src_b_q == fss_pkg::FSS_SRC_KEY);
  assign rtick = (tdir != 2'sd0) &
                 ((17'(rcnt_q) + 17'h1) >= {1'b0, rate_q});

  // Key adjust amount: save, clear, then steps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      kadj_q <= '0;
    else if (en) begin
      if (pwr_e & ~ksto_dis_q)
        kadj_q <= '0;
      else if (mfk_e & mfk_clr_q)
        kadj_q <= '0;
      else if (key_use & (kdir != 2'sd0))
        kadj_q <= fss_step(kadj_q, kinit_q, kdir, lowf_q, maxf_q);
    end
  end

  // Terminal rate counter, idle while no single input is closed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rcnt_q <= '0;
    else if (en) begin
      if ((tdir == 2'sd0) | rtick)
        rcnt_q <= '0;
      else
        rcnt_q <= rcnt_q + 16'h1;
    end
  end

  // Terminal adjust amount: save, clear, then rate steps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tadj_q <= '0;
    else if (en) begin
      if (pwr_e & ~tsto_dis_q)
        tadj_q <= '0;
      else if (tclr_e)
        tadj_q <= '0;
      else if (rtick)
        tadj_q <= fss_step(tadj_q, tinit_q, tdir, lowf_q, maxf_q);
    end
  end

  // Pulse gate: count edges on the sixth input per window
  assign gate_end = (gate_q == 20'(GATE_CYC - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_q <= '0;
      pcnt_q <= '0;
      phz_q  <= '0;
    end else if (en) begin
      if (gate_end) begin
        gate_q <= '0;
        phz_q  <= pcnt_q;
        pcnt_q <= {15'h0, pulse_e};
      end else begin
        gate_q <= gate_q + 20'h1;
        if (pulse_e & (pcnt_q != 16'hFFFF))
          pcnt_q <= pcnt_q + 16'h1;
      end
    end
  end

  // Pulse and potentiometer scaling onto zero..maximum
  assign pprod = ({16'h0, phz_q} * {16'h0, maxf_q}) / 32'(PFULL);
  assign pulse_sp = (pprod > {16'h0, maxf_q}) ? maxf_q : pprod[15:0];
  assign oprod = ({22'h0, pot_pos} * {16'h0, maxf_q}) / `FSS_POT_FULL;
  assign pot_sp = oprod[15:0];

  // Source table shared by A and B
  always_comb begin
    sv[0]  = kset;
    sv[1]  = tset;
    sv[2]  = comm_q;
    sv[3]  = srcs.ai1;
    sv[4]  = srcs.ai2;
    sv[5]  = pulse_sp;
    sv[6]  = srcs.seq;
    sv[7]  = srcs.mspd;
    sv[8]  = srcs.loop;
    sv[9]  = pot_sp;
    sv[10] = srcs.solar;
    sv[11] = srcs.pot2;
  end
  assign a_v = sv[src_a_q];
  assign b_v = sv[src_b_q];

  // Weighted auxiliary term K*B, K in hundredths
  assign kprod = ({16'h0, b_v} * {16'h0, k_q}) / `FSS_K_SCALE;
  assign as_c  = $signed({6'h0, a_v});
  assign kb_c  = $signed({2'h0, kprod[19:0]});

  // Combination of A and K*B
  always_comb begin
    case (mode_q)
      fss_pkg::FSS_MODE_A:     f_c = as_c;
      fss_pkg::FSS_MODE_ADD:   f_c = as_c + kb_c;
      fss_pkg::FSS_MODE_SUB:   f_c = as_c - kb_c;
      fss_pkg::FSS_MODE_ABS:
        f_c = (as_c < kb_c) ? kb_c - as_c : as_c - kb_c;
      fss_pkg::FSS_MODE_MAX:
        f_c = (as_c > kb_c) ? as_c : kb_c;
      fss_pkg::FSS_MODE_MIN:
        f_c = (as_c < kb_c) ? as_c : kb_c;
      fss_pkg::FSS_MODE_SWKB:
        f_c = sync2_q.sw_kb ? kb_c : as_c;
      fss_pkg::FSS_MODE_SWADD:
        f_c = sync2_q.sw_add ? as_c + kb_c : as_c;
      fss_pkg::FSS_MODE_SWSUB:
        f_c = sync2_q.sw_sub ? as_c - kb_c : as_c;
      default:                 f_c = as_c;
    endcase
  end

  // Final frequency, saturated to plus or minus maximum
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      fin_q <= '0;
    else if (en) begin
      if (f_c > $signed({6'h0, maxf_q}))
        fin_q <= $signed({2'h0, maxf_q});
      else if (f_c < -$signed({6'h0, maxf_q}))
        fin_q <= -$signed({2'h0, maxf_q});
      else
        fin_q <= f_c[17:0];
    end
  end

  // Bus phases: answer in the first access cycle
  assign setup = psel & ~penable;
  assign wr = en & psel & penable & pready_q & pwrite & ~pslverr_q;

  // Address decode and read data for the setup cycle
  always_comb begin
    miss = 1'b0;
    ro   = 1'b0;
    rd_c = 32'h0;
    case (paddr)
      `FSS_OFF_CTRL:  rd_c = {17'h0, mfk_clr_q, tsto_dis_q, ksto_dis_q,
                              mode_q, src_b_q, src_a_q};
      `FSS_OFF_KINIT: rd_c = {16'h0, kinit_q};
      `FSS_OFF_TINIT: rd_c = {16'h0, tinit_q};
      `FSS_OFF_WGT:   rd_c = {16'h0, k_q};
      `FSS_OFF_LIM:   rd_c = {maxf_q, lowf_q};
      `FSS_OFF_RATE:  rd_c = {16'h0, rate_q};
      `FSS_OFF_COMM:  rd_c = {16'h0, comm_q};
      `FSS_OFF_STAT: begin
        ro   = 1'b1;
        rd_c = {{14{fin_q[17]}}, fin_q};
      end
      `FSS_OFF_KADJ: begin
        ro   = 1'b1;
        rd_c = {{14{kadj_q[17]}}, kadj_q};
      end
      `FSS_OFF_TADJ: begin
        ro   = 1'b1;
        rd_c = {{14{tadj_q[17]}}, tadj_q};
      end
      default: miss = 1'b1;
    endcase
  end

  // Refused writes: out-of-range codes, weights, read-only words
  assign bad = miss | (pwrite & ro) |
    (pwrite & (paddr == `FSS_OFF_CTRL) &
     ((pwdata[7:4] > `FSS_SRC_LAST) | (pwdata[3:0] > `FSS_SRC_LAST) |
      (pwdata[11:8] > `FSS_MODE_LAST))) |
    (pwrite & (paddr == `FSS_OFF_WGT) &
     ((pwdata[15:0] < `FSS_K_MIN) | (pwdata[15:0] > `FSS_K_MAX)));

  // Bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else if (en) begin
      pready_q <= setup;
      if (setup) begin
        pslverr_q <= bad;
        prdata_q  <= (pwrite | miss) ? 32'h0 : rd_c;
      end
    end
  end

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_a_q    <= fss_pkg::fss_src_e'(`FSS_SRCA_RST);
      src_b_q    <= fss_pkg::fss_src_e'(`FSS_SRCB_RST);
      mode_q     <= fss_pkg::fss_mode_e'(`FSS_MODE_RST);
      ksto_dis_q <= 1'b0;
      tsto_dis_q <= 1'b0;
      mfk_clr_q  <= 1'b0;
    end else if (wr & (paddr == `FSS_OFF_CTRL)) begin
      src_a_q    <= fss_pkg::fss_src_e'(pwdata[`FSS_SRCA_LSB +: 4]);
      src_b_q    <= fss_pkg::fss_src_e'(pwdata[`FSS_SRCB_LSB +: 4]);
      mode_q     <= fss_pkg::fss_mode_e'(pwdata[`FSS_MODE_LSB +: 4]);
      ksto_dis_q <= pwdata[`FSS_KSTO_BIT];
      tsto_dis_q <= pwdata[`FSS_TSTO_BIT];
      mfk_clr_q  <= pwdata[`FSS_MFK_BIT];
    end
  end

  // Initial frequencies; a power-loss save wins over a bus write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kinit_q <= `FSS_INIT_RST;
      tinit_q <= `FSS_INIT_RST;
    end else if (en) begin
      if (pwr_e & ~ksto_dis_q)
        kinit_q <= kset;
      else if (wr & (paddr == `FSS_OFF_KINIT))
        kinit_q <= pwdata[15:0];
      if (pwr_e & ~tsto_dis_q)
        tinit_q <= tset;
      else if (wr & (paddr == `FSS_OFF_TINIT))
        tinit_q <= pwdata[15:0];
    end
  end

  // Weight, limits, rate and serial command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      k_q    <= `FSS_K_RST;
      lowf_q <= `FSS_LOWF_RST;
      maxf_q <= `FSS_MAXF_RST;
      rate_q <= `FSS_RATE_RST;
      comm_q <= '0;
    end else if (wr) begin
      case (paddr)
        `FSS_OFF_WGT:  k_q <= pwdata[15:0];
        `FSS_OFF_LIM: begin
          lowf_q <= pwdata[15:0];
          maxf_q <= pwdata[31:16];
        end
        `FSS_OFF_RATE: rate_q <= pwdata[15:0];
        `FSS_OFF_COMM: comm_q <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Checks
  default clocking dflt_cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_key_step: assert property (
    en & key_up_e & ~key_dn_e & key_use & ~pwr_e & ~(mfk_e & mfk_clr_q) &
    (kset < maxf_q) & (kset >= lowf_q) |=> kadj_q == $past(kadj_q) + 18'sd1)
    else $error("key step up lost");
  chk_key_save: assert property (
    en & pwr_e & ~ksto_dis_q |=> (kinit_q == $past(kset)) && (kadj_q == 0))
    else $error("key save wrong");
  chk_key_nosave: assert property (
    en & pwr_e & ksto_dis_q & ~(wr & (paddr == `FSS_OFF_KINIT))
    |=> $stable(kinit_q))
    else $error("key saved while disabled");
  chk_term_save: assert property (
    en & pwr_e & ~tsto_dis_q |=> (tinit_q == $past(tset)) && (tadj_q == 0))
    else $error("terminal save wrong");
  chk_term_hold: assert property (
    en & (sync2_q.term_up == sync2_q.term_down) & ~tclr_e & ~pwr_e
    |=> $stable(tadj_q))
    else $error("terminal moved while held");
  chk_term_rate: assert property (
    en & ~tclr_e & ~pwr_e & ~rtick |=> $stable(tadj_q))
    else $error("terminal stepped off rate");
  chk_term_clear: assert property (
    en & tclr_e & ~(pwr_e & ~tsto_dis_q) |=> tadj_q == 0)
    else $error("terminal clear ignored");
  chk_key_clear: assert property (
    en & mfk_e & mfk_clr_q |=> kadj_q == 0)
    else $error("key clear ignored");
  chk_setp_range: assert property (
    (lowf_q <= maxf_q) |-> (tset >= lowf_q) && (tset <= maxf_q))
    else $error("terminal setpoint out of range");
  chk_mode_min: assert property (
    en & (mode_q == fss_pkg::FSS_MODE_MIN) & (as_c <= kb_c) &
    ({2'h0, a_v} <= {2'h0, maxf_q}) |=> fin_q == $signed({2'h0, $past(a_v)}))
    else $error("minimum mode wrong");
  chk_apb_miss: assert property (
    en & setup & miss |=> pready_q & pslverr_q & (prdata_q == 32'h0))
    else $error("unmapped access not refused");

  cov_term_ramp: cover property (en & rtick & (tdir == 2'sd1) ##2 en & rtick);
  cov_key_save:  cover property (en & pwr_e & ~ksto_dis_q);
  cov_abs_neg:   cover property (
    en & (mode_q == fss_pkg::FSS_MODE_ABS) & (as_c < kb_c));
  cov_switch:    cover property (
    en & (mode_q == fss_pkg::FSS_MODE_SWKB) & sync2_q.sw_kb);

endmodule // fss_top
